// [rtl/cmpctl_pkg.sv]
package cmpctl_pkg;
  // ----------------------------------------------------------------
  // Register map, word indices on the register port.
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_EDGE_IRQ_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_NEGATIVE_INPUT_SELECT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] ADDR_SLEEP_CONTROL = 4'h5;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int BIT_RESULT = 6;
  localparam int BIT_INVERT = 4;
  localparam int BIT_HYST = 1;
  localparam int BIT_SYNC = 0;
  localparam int BIT_RISE_EN = 1;
  localparam int BIT_FALL_EN = 0;
  localparam int BIT_FLAG = 0;
  localparam int BIT_SLEEP = 0;
  localparam int BIT_TIMER_SYSCLK = 1;
  localparam int CHAN_W = 3;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_CHAN = 3'h0;
endpackage

// [rtl/cmpctl_top.sv]
// Local design decisions: strobed register access and the address map.
module cmpctl_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Analog core and timer.
  input wire logic raw_compare,
  input wire logic sync_timer_clock,
  output logic comparator_enable,
  output logic hysteresis_enable,
  output logic [2:0] negative_channel_select,
  output logic comparator_out,
  // Interrupt and wake.
  output logic irq,
  output logic wake_request
);
  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] raw_sync;
    logic [2:0] tclk_sync;
    logic raw_level;
    logic tclk_level;
    logic enable;
    logic invert;
    logic hyst;
    logic sync_mode;
    logic rise_en;
    logic fall_en;
    logic [2:0] chan;
    logic mask;
    logic sleeping;
    logic timer_sysclk;
    logic result;
    logic flag;
    logic [7:0] rdata;
    logic irq;
    logic wake;
  } cmpctl_state_t;

  cmpctl_state_t state;
  cmpctl_state_t next_state;
  logic raw_valid;
  logic tclk_rise;
  logic polar;
  logic sync_ok;
  logic rise_ev;
  logic fall_ev;
  logic flag_set;

  // Agreed comparator level, kept in the state beside its synchroniser.
  assign raw_valid = state.raw_level;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.raw_sync = {state.raw_sync[1:0], raw_compare};
    next_state.tclk_sync = {state.tclk_sync[1:0], sync_timer_clock};
    // A pin change counts only once the second and third stages agree.
    if (state.raw_sync[1] == state.raw_sync[2]) begin
      next_state.raw_level = state.raw_sync[2];
    end
    if (state.tclk_sync[1] == state.tclk_sync[2]) begin
      next_state.tclk_level = state.tclk_sync[2];
    end
    // A timer clock edge is the agreed level going from low to high.
    tclk_rise = next_state.tclk_level & ~state.tclk_level;
    polar = raw_valid ^ state.invert;
    // The timer stops when it is clocked from the system clock in sleep.
    sync_ok = ~(state.sleeping & state.timer_sysclk);
    if (!state.sync_mode) begin
      next_state.result = polar;
    end else if (sync_ok && tclk_rise) begin
      next_state.result = polar;
    end
    if (!state.enable) begin
      next_state.result = 1'b0;
    end
    rise_ev = next_state.result & ~state.result & state.rise_en;
    fall_ev = ~next_state.result & state.result & state.fall_en;
    flag_set = rise_ev | fall_ev;
    next_state.rdata = cmpctl_pkg::RESET_BYTE;
    if (reg_read) begin
      case (reg_addr)
        cmpctl_pkg::ADDR_CONTROL_ZERO: begin
          next_state.rdata[cmpctl_pkg::BIT_ENABLE] = state.enable;
          next_state.rdata[cmpctl_pkg::BIT_RESULT] = state.result;
          next_state.rdata[cmpctl_pkg::BIT_INVERT] = state.invert;
          next_state.rdata[cmpctl_pkg::BIT_HYST] = state.hyst;
          next_state.rdata[cmpctl_pkg::BIT_SYNC] = state.sync_mode;
        end
        cmpctl_pkg::ADDR_EDGE_IRQ_CONTROL: begin
          next_state.rdata[cmpctl_pkg::BIT_RISE_EN] = state.rise_en;
          next_state.rdata[cmpctl_pkg::BIT_FALL_EN] = state.fall_en;
        end
        cmpctl_pkg::ADDR_NEGATIVE_INPUT_SELECT: begin
          next_state.rdata[cmpctl_pkg::CHAN_W-1:0] = state.chan;
        end
        cmpctl_pkg::ADDR_IRQ_STATUS: begin
          next_state.rdata[cmpctl_pkg::BIT_FLAG] = state.flag;
          next_state.flag = 1'b0;
        end
        cmpctl_pkg::ADDR_IRQ_MASK: begin
          next_state.rdata[cmpctl_pkg::BIT_FLAG] = state.mask;
        end
        cmpctl_pkg::ADDR_SLEEP_CONTROL: begin
          next_state.rdata[cmpctl_pkg::BIT_SLEEP] = state.sleeping;
          next_state.rdata[cmpctl_pkg::BIT_TIMER_SYSCLK] = state.timer_sysclk;
        end
        default: begin
          next_state.rdata = cmpctl_pkg::RESET_BYTE;
        end
      endcase
    end
    if (reg_write) begin
      case (reg_addr)
        cmpctl_pkg::ADDR_CONTROL_ZERO: begin
          next_state.enable = reg_wdata[cmpctl_pkg::BIT_ENABLE];
          next_state.invert = reg_wdata[cmpctl_pkg::BIT_INVERT];
          next_state.hyst = reg_wdata[cmpctl_pkg::BIT_HYST];
          next_state.sync_mode = reg_wdata[cmpctl_pkg::BIT_SYNC];
        end
        cmpctl_pkg::ADDR_EDGE_IRQ_CONTROL: begin
          next_state.rise_en = reg_wdata[cmpctl_pkg::BIT_RISE_EN];
          next_state.fall_en = reg_wdata[cmpctl_pkg::BIT_FALL_EN];
        end
        cmpctl_pkg::ADDR_NEGATIVE_INPUT_SELECT: begin
          next_state.chan = reg_wdata[cmpctl_pkg::CHAN_W-1:0];
        end
        cmpctl_pkg::ADDR_IRQ_MASK: begin
          next_state.mask = reg_wdata[cmpctl_pkg::BIT_FLAG];
        end
        cmpctl_pkg::ADDR_SLEEP_CONTROL: begin
          next_state.sleeping = reg_wdata[cmpctl_pkg::BIT_SLEEP];
          next_state.timer_sysclk = reg_wdata[cmpctl_pkg::BIT_TIMER_SYSCLK];
        end
        default: begin
          next_state.mask = state.mask;
        end
      endcase
    end
    // A new edge wins over a clearing read.
    if (flag_set) begin
      next_state.flag = 1'b1;
    end
    next_state.irq = next_state.flag & next_state.mask;
    // Interrupt wakes the part when enabled.
    next_state.wake = next_state.flag & next_state.mask & next_state.sleeping;
  end

  // Register the state; reset loads zeros.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign reg_rdata = state.rdata;
  assign comparator_enable = state.enable;
  assign hysteresis_enable = state.hyst;
  assign negative_channel_select = state.chan;
  assign comparator_out = state.result;
  assign irq = state.irq;
  assign wake_request = state.wake;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  // Comparator output rising or falling across one clock.
  sequence s_out_rise;
    state.rise_en && !comparator_out ##1 comparator_out;
  endsequence
  sequence s_out_fall;
    state.fall_en && comparator_out ##1 !comparator_out;
  endsequence
  // Synchronised mode asleep on the system clock, then still synchronised.
  sequence s_sleep_held;
    state.sync_mode && state.sleeping && state.timer_sysclk && state.enable
      ##1 state.sync_mode && state.enable;
  endsequence

  a_async_follow: assert property (@(posedge clock) disable iff (sys_rst)
    state.enable && !state.sync_mode && $stable(state.invert) && $stable(state.enable)
      |=> comparator_out == ($past(raw_valid) ^ $past(state.invert)))
    else $error("Result does not follow polarity in async mode.");
  a_hyst_pin: assert property (@(posedge clock) disable iff (sys_rst)
    reg_write && reg_addr == cmpctl_pkg::ADDR_CONTROL_ZERO
      |=> hysteresis_enable == $past(reg_wdata[cmpctl_pkg::BIT_HYST]))
    else $error("Hysteresis output does not match written bit.");
  a_sync_hold: assert property (@(posedge clock) disable iff (sys_rst)
    state.sync_mode && $past(state.sync_mode) && $past(state.enable) && !$past(tclk_rise)
      |-> $stable(comparator_out))
    else $error("Synchronised result moved without a timer edge.");
  a_rise_flag: assert property (@(posedge clock) disable iff (sys_rst)
    s_out_rise |-> state.flag)
    else $error("Rising edge did not set flag.");
  a_fall_flag: assert property (@(posedge clock) disable iff (sys_rst)
    s_out_fall |-> state.flag)
    else $error("Falling edge did not set flag.");
  a_chan_read: assert property (@(posedge clock) disable iff (sys_rst)
    reg_read && reg_addr == cmpctl_pkg::ADDR_NEGATIVE_INPUT_SELECT
      |=> reg_rdata == {5'h00, $past(state.chan)})
    else $error("Channel select read is wrong.");
  a_sleep_stop: assert property (@(posedge clock) disable iff (sys_rst)
    s_sleep_held |-> $stable(comparator_out))
    else $error("Synchronised result moved during sleep.");
  a_wake_irq: assert property (@(posedge clock) disable iff (sys_rst)
    state.flag && state.mask && state.sleeping |-> wake_request)
    else $error("Enabled interrupt did not wake.");
  a_result_read: assert property (@(posedge clock) disable iff (sys_rst)
    reg_read && reg_addr == cmpctl_pkg::ADDR_CONTROL_ZERO
      |=> reg_rdata[cmpctl_pkg::BIT_RESULT] == $past(comparator_out))
    else $error("Result bit read is wrong.");
endmodule

// [testbench/cmpctl_analog_model.sv]
// ----------------------------------------------------------------
// Behavioural analog comparator core.
// ----------------------------------------------------------------
module cmpctl_analog_model (
  // Clock.
  input wire logic clock,
  // Controls from the block and the bench.
  input wire logic comparator_enable,
  input wire logic hysteresis_enable,
  input wire logic level,
  // Result to the block.
  output logic raw_compare
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held = 1'b0;
  logic wobble = 1'b0;
  // Hysteresis delays the decision one cycle; an off core gives a changing pattern.
  always_ff @(posedge clock) begin
    held <= level;
    wobble <= ~wobble;
  end
  assign raw_compare = !comparator_enable ? wobble : (hysteresis_enable ? held : level);
endmodule

// [testbench/test_comparator_control_regs.sv]
// ----------------------------------------------------------------
// Self-checking bench for the comparator control block.
// ----------------------------------------------------------------
module test_comparator_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sync_timer_clock = 1'b0;
  logic level = 1'b0;
  logic raw_compare, comparator_enable, hysteresis_enable, comparator_out, irq, wake_request;
  logic [2:0] negative_channel_select;
  logic [7:0] reg_rdata;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  cmpctl_top u_cmpctl_top (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .raw_compare(raw_compare), .sync_timer_clock(sync_timer_clock),
    .comparator_enable(comparator_enable), .hysteresis_enable(hysteresis_enable),
    .negative_channel_select(negative_channel_select), .comparator_out(comparator_out),
    .irq(irq), .wake_request(wake_request));
  cmpctl_analog_model u_cmpctl_analog_model (.clock(clock),
    .comparator_enable(comparator_enable), .hysteresis_enable(hysteresis_enable),
    .level(level), .raw_compare(raw_compare));

  // Clock generation and hang limit.
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // One-cycle register read, data judged in the following cycle.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(name, exp, reg_rdata);
  endtask
  // Lets the input pipeline settle.
  task automatic settle;
    repeat (8) @(posedge clock);
    #1;
  endtask

  // Reset values, channel field and unmapped space.
  task automatic t_regs;
    rd(4'h0, 8'h00, "control_zero");
    rd(4'h1, 8'h00, "edge_control");
    rd(4'h2, 8'h00, "negative_select");
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h07, "negative_select");
    chk("channel_port", 8'h07, {5'h00, negative_channel_select});
    rd(4'hf, 8'h00, "unmapped");
  endtask
  // Polarity, hysteresis and result bit.
  task automatic t_polarity;
    @(posedge clock) level <= 1'b1;
    wr(4'h0, 8'h82);
    settle();
    chk("hyst_port", 8'h01, {7'h00, hysteresis_enable});
    chk("out_plain", 8'h01, {7'h00, comparator_out});
    rd(4'h0, 8'hc2, "result_plain");
    wr(4'h0, 8'h90);
    settle();
    chk("out_invert", 8'h00, {7'h00, comparator_out});
    rd(4'h0, 8'h90, "result_invert");
  endtask
  // Edge flags, mask, status clear and wake.
  task automatic t_edges;
    wr(4'h0, 8'h80);
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h02);
    rd(4'h3, 8'h00, "status_stale");
    @(posedge clock) level <= 1'b0;
    settle();
    chk("irq_fall_off", 8'h00, {7'h00, irq});
    @(posedge clock) level <= 1'b1;
    settle();
    chk("irq_rise", 8'h01, {7'h00, irq});
    wr(4'h5, 8'h01);
    #1 chk("wake", 8'h01, {7'h00, wake_request});
    rd(4'h3, 8'h01, "status_rise");
    #1 chk("irq_cleared", 8'h00, {7'h00, irq});
    wr(4'h1, 8'h01);
    @(posedge clock) level <= 1'b0;
    settle();
    chk("irq_fall", 8'h01, {7'h00, irq});
    rd(4'h3, 8'h01, "status_fall");
    wr(4'h5, 8'h00);
  endtask
  // Synchronous mode follows only timer clock edges.
  task automatic t_sync;
    wr(4'h0, 8'h81);
    settle();
    @(posedge clock) level <= 1'b1;
    settle();
    chk("sync_hold", 8'h00, {7'h00, comparator_out});
    @(posedge clock) sync_timer_clock <= 1'b1;
    settle();
    chk("sync_edge", 8'h01, {7'h00, comparator_out});
    @(posedge clock) sync_timer_clock <= 1'b0;
    settle();
    // Asleep with the timer on the system clock, so timer edges are lost.
    wr(4'h5, 8'h03);
    @(posedge clock) level <= 1'b0;
    settle();
    @(posedge clock) sync_timer_clock <= 1'b1;
    settle();
    chk("sync_asleep", 8'h01, {7'h00, comparator_out});
    wr(4'h5, 8'h00);
    @(posedge clock) sync_timer_clock <= 1'b0;
    settle();
    @(posedge clock) sync_timer_clock <= 1'b1;
    settle();
    chk("sync_awake", 8'h00, {7'h00, comparator_out});
    chk("irq_sync_fall", 8'h01, {7'h00, irq});
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_polarity();
    t_edges();
    t_sync();
    complete_run();
  end
endmodule
